// File: hw/fpfc_core.sv
// Flyback PWM control core with protection sequencing and APB registers
//
// Overview of operation
// RL1 - Gate stays off until supply reaches turn-on level, then switching starts.
// RL2 - Heavy load switches at nominal 65 kHz.
// RL3 - Below 2.2 V feedback, frequency falls linearly toward 22.5 kHz.
// RL4 - Below 2.1 V feedback, frequency fixed at minimum, deep green state.
// RL5 - Below 1.7 V feedback, switching stops; resumes once feedback rises.
// RL6 - Frequency sweeps 60.8 to 69.2 kHz with 4.4 ms period.
// RL7 - Auto-restart fault ends switching and holds gate off.
// RL8 - Auto-restart clears at 8.5 V supply, resumes at 16 V.
// RL9 - Latch fault stops switching until supply falls below 4 V.
// RL10 - Supply overvoltage and overtemperature latch; others auto-restart.
// RL11 - Current limit ends gate pulse for rest of cycle.
// RL12 - Overcurrent held beyond 56 ms shuts gate as a fault.
// RL13 - Feedback above 4.6 V beyond 56 ms raises open-loop fault.
// RL14 - Supply overvoltage at 25 V faults after 30 us debounce.
// RL15 - Thermistor below 1.0 V for debounce time disables gate.
// RL16 - Thermistor below 0.7 V latches after shorter debounce.
// RL17 - Shorter thermal debounce is 100 us.
// RL18 - Current-limit reference rises as sawtooth within each cycle.
// RL19 - Current sense ignored for 360 ns after gate turn-on.
// RL20 - Current-limit reference ramps up over 4 ms after start.
// RL21 - Faults and burst-off force gate low at once.
// RL22 - Flags synchronised; debounce timers restart when condition drops.
//
// Register access over APB and the register offsets were decided locally.
`timescale 1ns/1ps
`default_nettype none

module fpfc_core #(
  parameter int OPEN_CYC  = fpfc_pkg::OPEN_DLY_CYC,
  parameter int THERM_CYC = fpfc_pkg::THERM_CYC,
  parameter int HOP_CYC   = fpfc_pkg::HOP_CYC,
  parameter int SOFT_CYC  = fpfc_pkg::SOFT_CYC,
  parameter bit LATCH_ALL = 1'b0
) (
  // Clock and reset
  input  wire logic               clk,
  input  wire logic               rst_b,
  // Comparator flags
  input  wire fpfc_pkg::fpfc_cmp_t cmp,
  input  wire logic [7:0]         fb_level,
  // APB slave
  input  wire fpfc_pkg::fpfc_apb_t apb,
  output logic [31:0]             prdata,
  output logic                    pready,
  output logic                    pslverr,
  // Power stage
  output logic                    gate_drive,
  output logic [7:0]              cl_ref,
  output logic                    deep_green,
  output logic                    burst_off
);

  // ----------------------------------------
  // State
  // ----------------------------------------
  localparam int SOFT_STEP = SOFT_CYC / 256;
  localparam int HOP_STEP  = HOP_CYC / (2 * int'(fpfc_pkg::HOP_SPAN));
  localparam logic [21:0] LIM_OPEN  = 22'(OPEN_CYC);
  localparam logic [21:0] LIM_THERM = 22'(THERM_CYC);
  localparam logic [21:0] LIM_VOVER = 22'(fpfc_pkg::VOVER_CYC);
  // RL17 short thermal debounce
  localparam logic [21:0] LIM_CRIT  = 22'(fpfc_pkg::THERM2_CYC);
  localparam logic [4:0]  BLANK     = 5'(fpfc_pkg::BLANK_CYC);
  // Overcurrent shares the open-loop delay
  localparam logic [4:0][21:0] LIM = {LIM_CRIT, LIM_THERM, LIM_VOVER,
                                      LIM_OPEN, LIM_OPEN};

  typedef struct packed {
    fpfc_pkg::fpfc_state_t st;
    fpfc_pkg::fpfc_cmp_t   s1;
    fpfc_pkg::fpfc_cmp_t   s2;
    logic [7:0]            lvl1;
    logic [7:0]            lvl2;
    logic [11:0]           cnt;
    logic [11:0]           per;
    logic [11:0]           ton_max;
    logic [4:0]            blank;
    logic [4:0]            on_cnt;
    logic [6:0]            hop;
    logic                  hop_dn;
    logic [17:0]           hop_tmr;
    logic [7:0]            ss;
    logic [17:0]           ss_tmr;
    logic [4:0][21:0]      dly;
    logic [4:0]            hit;
    logic                  gate;
    logic                  burst;
    logic                  deep;
    logic [7:0]            cl;
    logic [1:0]            ctrl;
    logic [5:0]            cause;
    logic                  pready;
    logic                  pslverr;
    logic [31:0]           prdata;
  } fpfc_core_st_t;

  fpfc_core_st_t q;
  fpfc_core_st_t n;
  logic [4:0]    cond;
  logic          quiet;
  logic [11:0]   per_sel;
  logic [18:0]   g_prod;
  logic [19:0]   d_prod;
  logic [7:0]    saw;
  logic          wr;
  logic          latch_ev;
  logic          arst_ev;

  assign cond = {q.s2.therm_crit, q.s2.therm_warn, q.s2.vdd_over,
                 q.s2.cs_over, q.s2.fb_open};

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb
  begin
    n = q;
    // RL22 two-stage sync
    n.s1   = cmp;
    n.s2   = q.s1;
    n.lvl1 = fb_level;
    n.lvl2 = q.lvl1;

    // RL22 debounce restart
    for (int i = 0; i < fpfc_pkg::NDLY; i++)
    begin
      if (!cond[i])
        n.dly[i] = '0;
      else if (q.dly[i] != LIM[i])
        n.dly[i] = q.dly[i] + 22'h1;
      n.hit[i] = cond[i] && (q.dly[i] == LIM[i]);
    end

    // RL12 RL13 delayed faults
    arst_ev = q.hit[fpfc_pkg::D_OPEN] || q.hit[fpfc_pkg::D_OVERC] ||
              q.s2.cs_short;
    // RL10 fault classes
    latch_ev = q.hit[fpfc_pkg::D_VOVER] || q.hit[fpfc_pkg::D_CRIT] ||
               (LATCH_ALL && arst_ev);

    case (q.st)
      fpfc_pkg::ST_OFF:
      begin
        // RL1 wait for turn-on level
        if (q.s2.vdd_on)
          n.st = fpfc_pkg::ST_RUN;
      end
      fpfc_pkg::ST_RUN:
      begin
        // RL14 RL16 latch entry
        if (latch_ev)
          n.st = fpfc_pkg::ST_LATCH;
        // RL7 stop on restart fault
        else if (arst_ev)
          n.st = fpfc_pkg::ST_ARST;
        else if (q.s2.vdd_off)
          n.st = fpfc_pkg::ST_OFF;
      end
      fpfc_pkg::ST_ARST:
      begin
        // RL8 clear at turn-off level
        if (q.s2.vdd_off)
          n.st = fpfc_pkg::ST_OFF;
      end
      fpfc_pkg::ST_LATCH:
      begin
        // RL9 release on discharge
        if (q.s2.vdd_clear)
          n.st = fpfc_pkg::ST_OFF;
      end
      default: n.st = fpfc_pkg::ST_OFF;
    endcase

    // RL6 triangular hop sweep
    if (q.hop_tmr >= 18'(HOP_STEP - 1))
    begin
      n.hop_tmr = '0;
      if (q.hop_dn)
      begin
        n.hop = q.hop - 7'h1;
        n.hop_dn = (q.hop != 7'h1);
      end
      else
      begin
        n.hop = q.hop + 7'h1;
        n.hop_dn = (q.hop + 7'h1 == fpfc_pkg::HOP_SPAN);
      end
    end
    else
      n.hop_tmr = q.hop_tmr + 18'h1;

    // RL3 linear reduction band
    g_prod = 19'(fpfc_pkg::G_SPAN * q.lvl2);
    if (q.s2.fb_min)
      // RL4 fixed minimum frequency
      per_sel = fpfc_pkg::P_GREEN;
    else if (q.s2.fb_nred)
      per_sel = fpfc_pkg::P_GREEN - {1'b0, g_prod[18:8]};
    else if (q.ctrl[fpfc_pkg::B_HOP])
      per_sel = fpfc_pkg::P_HOPMIN + {5'h0, q.hop};
    else
      // RL2 nominal frequency
      per_sel = fpfc_pkg::P_NOM;
    d_prod = 20'(per_sel * fpfc_pkg::DUTY_NUM);

    // RL20 soft-start ramp
    if (q.st != fpfc_pkg::ST_RUN)
    begin
      n.ss = '0;
      n.ss_tmr = '0;
    end
    else if (q.ss_tmr >= 18'(SOFT_STEP - 1))
    begin
      n.ss_tmr = '0;
      if (q.ss != 8'hff)
        n.ss = q.ss + 8'h1;
    end
    else
      n.ss_tmr = q.ss_tmr + 18'h1;

    // RL5 burst gating
    n.burst = q.s2.fb_zero && q.st == fpfc_pkg::ST_RUN;
    n.deep  = q.s2.fb_min && q.st == fpfc_pkg::ST_RUN;

    // RL21 override of pulse logic
    quiet = q.st != fpfc_pkg::ST_RUN || n.st != fpfc_pkg::ST_RUN ||
            q.s2.fb_zero || q.hit[fpfc_pkg::D_HOT] ||
            !q.ctrl[fpfc_pkg::B_EN];

    if (q.cnt >= q.per - 12'h1)
    begin
      n.cnt = '0;
      n.per = per_sel;
      n.ton_max = d_prod[19:8];
      n.gate = 1'b1;
      // RL19 blanking after turn-on
      n.blank = BLANK;
    end
    else
    begin
      n.cnt = q.cnt + 12'h1;
      if (q.blank != 5'h0)
        n.blank = q.blank - 5'h1;
      // RL11 cycle-by-cycle limit
      if ((q.blank == 5'h0 && q.s2.cs_limit) || q.cnt >= q.ton_max)
        n.gate = 1'b0;
    end
    // RL15 thermal disable
    if (quiet)
      n.gate = 1'b0;
    n.on_cnt = !n.gate ? 5'h0 :
               (q.on_cnt == 5'h1f ? q.on_cnt : q.on_cnt + 5'h1);

    // RL18 sawtooth limit reference
    if (q.cnt[11:fpfc_pkg::SAW_SHIFT] >= 8'(fpfc_pkg::SAW_FLAT - fpfc_pkg::SAW_VALLEY))
      saw = fpfc_pkg::SAW_FLAT;
    else
      saw = fpfc_pkg::SAW_VALLEY + q.cnt[fpfc_pkg::SAW_SHIFT+7:fpfc_pkg::SAW_SHIFT];
    n.cl = (q.ss < saw) ? q.ss : saw;

    // APB slave, zero wait states
    wr = apb.psel && apb.penable && q.pready && apb.pwrite;
    n.pready = apb.psel && !apb.penable;
    n.pslverr = 1'b0;
    n.prdata = q.prdata;
    if (apb.psel && !apb.penable)
    begin
      n.prdata = '0;
      if (apb.paddr == fpfc_pkg::A_CTRL)
        n.prdata = {30'h0, q.ctrl};
      else if (apb.paddr == fpfc_pkg::A_STATUS)
        n.prdata = {20'h0, q.hit, q.deep, q.burst, q.gate, q.st, 2'h0};
      else if (apb.paddr == fpfc_pkg::A_CAUSE)
        n.prdata = {26'h0, q.cause};
      else if (apb.paddr == fpfc_pkg::A_PERIOD)
        n.prdata = {20'h0, q.per};
      else
        n.pslverr = 1'b1;
    end
    if (wr && apb.paddr == fpfc_pkg::A_CTRL)
      n.ctrl = apb.pwdata[1:0];
    // Hardware set beats software clear
    if (wr && apb.paddr == fpfc_pkg::A_CAUSE)
      n.cause = q.cause & ~apb.pwdata[5:0];
    if (q.st == fpfc_pkg::ST_RUN)
      n.cause = n.cause | {q.s2.cs_short, q.hit};
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      q <= '0;
      q.per <= fpfc_pkg::P_NOM;
      q.ctrl <= fpfc_pkg::CTRL_RST;
    end
    else
      q <= n;
  end

  assign prdata     = q.prdata;
  assign pready     = q.pready;
  assign pslverr    = q.pslverr;
  assign gate_drive = q.gate;
  assign cl_ref     = q.cl;
  assign deep_green = q.deep;
  assign burst_off  = q.burst;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  sequence s_gate_rise;
    !q.gate ##1 q.gate;
  endsequence

  sequence s_gate_fall;
    q.gate ##1 !q.gate;
  endsequence

  a_gate_idle: assert property ( // RL1
    q.st == fpfc_pkg::ST_OFF |=> !q.gate)
    else $error("gate active before turn-on");

  a_burst_stop: assert property ( // RL5
    q.s2.fb_zero ##1 q.s2.fb_zero |-> !q.gate)
    else $error("gate active in burst-off");

  a_blank_hold: assert property ( // RL19
    s_gate_fall |-> $past(q.on_cnt) >= BLANK || $past(quiet)
                    || $past(q.cnt) >= $past(q.ton_max))
    else $error("gate cut inside blanking");

  a_rise_start: assert property ( // RL11
    s_gate_rise |-> q.cnt == 12'h0 && q.blank == BLANK)
    else $error("gate rose off cycle start");

  a_latch_enter: assert property ( // RL14
    q.st == fpfc_pkg::ST_RUN && q.hit[fpfc_pkg::D_VOVER]
    |=> q.st == fpfc_pkg::ST_LATCH ##1 !q.gate)
    else $error("overvoltage did not latch");

  a_latch_keep: assert property ( // RL9
    q.st == fpfc_pkg::ST_LATCH && !q.s2.vdd_clear
    |=> q.st == fpfc_pkg::ST_LATCH && !q.gate)
    else $error("latch released early");

  a_arst_cycle: assert property ( // RL8
    q.st == fpfc_pkg::ST_ARST && q.s2.vdd_off |=> q.st == fpfc_pkg::ST_OFF)
    else $error("restart not cleared at turn-off");

  a_dly_reset: assert property ( // RL22
    !q.s2.cs_over |=> q.dly[fpfc_pkg::D_OVERC] == 22'h0)
    else $error("overcurrent timer kept count");

  a_per_range: assert property ( // RL3
    q.per >= fpfc_pkg::P_HOPMIN && q.per <= fpfc_pkg::P_GREEN)
    else $error("period out of range");

  a_deep_fixed: assert property ( // RL4
    q.s2.fb_min && q.cnt >= q.per - 12'h1 |=> q.per == fpfc_pkg::P_GREEN)
    else $error("minimum frequency not fixed");

  a_therm_off: assert property ( // RL15
    q.hit[fpfc_pkg::D_HOT] |=> !q.gate)
    else $error("gate active when hot");

  a_ss_bound: assert property ( // RL20
    q.st != fpfc_pkg::ST_RUN |=> q.ss == 8'h0 ##1 q.cl <= 8'h1)
    else $error("soft-start not restarted");

endmodule : fpfc_core

`default_nettype wire

// File: inc/fpfc_pkg.sv
// Constants and types of the flyback PWM fault control core
package fpfc_pkg;

  // ----------------------------------------
  // Clock and timing
  // ----------------------------------------
  localparam int CLK_HZ      = 40_000_000;
  localparam int CLK_MHZ     = CLK_HZ / 1_000_000;
  localparam int OPEN_DLY_MS = 56;
  localparam int VOVER_US    = 30;
  localparam int THERM_MS    = 17;
  localparam int THERM2_US   = 100;
  localparam int HOP_US      = 4400;
  localparam int SOFT_MS     = 4;
  localparam int BLANK_NS    = 360;
  localparam int OPEN_DLY_CYC = (CLK_HZ / 1000) * OPEN_DLY_MS;
  localparam int VOVER_CYC    = CLK_MHZ * VOVER_US;
  localparam int THERM_CYC    = (CLK_HZ / 1000) * THERM_MS;
  localparam int THERM2_CYC   = CLK_MHZ * THERM2_US;
  localparam int HOP_CYC      = CLK_MHZ * HOP_US;
  localparam int SOFT_CYC     = (CLK_HZ / 1000) * SOFT_MS;
  localparam int BLANK_CYC    = (BLANK_NS * CLK_MHZ + 999) / 1000;

  // ----------------------------------------
  // Switching periods in clock cycles
  // ----------------------------------------
  localparam int F_NOM_HZ   = 65000;
  localparam int F_HOPLO_HZ = 60800;
  localparam int F_HOPHI_HZ = 69200;
  localparam int F_MIN_HZ   = 22500;
  localparam logic [11:0] P_NOM    = 12'(CLK_HZ / F_NOM_HZ);
  localparam logic [11:0] P_HOPMIN = 12'(CLK_HZ / F_HOPHI_HZ);
  localparam logic [11:0] P_HOPMAX = 12'(CLK_HZ / F_HOPLO_HZ);
  localparam logic [11:0] P_GREEN  = 12'(CLK_HZ / F_MIN_HZ);
  localparam logic [6:0]  HOP_SPAN = 7'(P_HOPMAX - P_HOPMIN);
  localparam logic [10:0] G_SPAN   = 11'(P_GREEN - P_NOM);
  localparam logic [7:0]  DUTY_NUM = 8'hb3;
  localparam logic [7:0]  SAW_VALLEY = 8'he1;
  localparam logic [7:0]  SAW_FLAT   = 8'hff;
  localparam int          SAW_SHIFT  = 4;

  // ----------------------------------------
  // Register map
  // ----------------------------------------
  localparam logic [11:0] A_CTRL   = 12'h000;
  localparam logic [11:0] A_STATUS = 12'h004;
  localparam logic [11:0] A_CAUSE  = 12'h008;
  localparam logic [11:0] A_PERIOD = 12'h00c;
  localparam int B_EN  = 0;
  localparam int B_HOP = 1;
  localparam logic [1:0] CTRL_RST = 2'h3;

  // ----------------------------------------
  // Debounce channels
  // ----------------------------------------
  localparam int NDLY    = 5;
  localparam int D_OPEN  = 0;
  localparam int D_OVERC = 1;
  localparam int D_VOVER = 2;
  localparam int D_HOT   = 3;
  localparam int D_CRIT  = 4;

  typedef enum logic [1:0] {
    ST_OFF   = 2'b00,
    ST_RUN   = 2'b01,
    ST_ARST  = 2'b10,
    ST_LATCH = 2'b11
  } fpfc_state_t;

  typedef struct packed {
    logic vdd_on;
    logic vdd_off;
    logic vdd_clear;
    logic vdd_over;
    logic fb_nred;
    logic fb_min;
    logic fb_zero;
    logic fb_open;
    logic cs_limit;
    logic cs_over;
    logic cs_short;
    logic therm_warn;
    logic therm_crit;
  } fpfc_cmp_t;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } fpfc_apb_t;

endpackage : fpfc_pkg

// File: verif/fpfc_fet_model.sv
// Current-sense model of the external switch and its sense resistor
`timescale 1ns/1ps
`default_nettype none
module fpfc_fet_model (
  // Clock
  input  wire logic        clk,
  // Gate and trip point
  input  wire logic        gate_drive,
  input  wire logic [15:0] trip,
  // Sense flag
  output logic             cs_limit
);
  logic [15:0] on_cyc = 16'h0;

  // ----------------------------------------
  // Drain current ramps while on; none once off
  // ----------------------------------------
  always_ff @(posedge clk)
  begin
    on_cyc   <= gate_drive ? on_cyc + 16'h1 : 16'h0;
    cs_limit <= gate_drive && (on_cyc >= trip);
  end
endmodule : fpfc_fet_model
`default_nettype wire

// File: verif/tb_flyback_pwm_fault_control.sv
// Testbench of the flyback PWM fault control core
`timescale 1ns/1ps
`default_nettype none
module tb_flyback_pwm_fault_control;
  // ----------------------------------------
  // Signals
  // ----------------------------------------
  logic                clk;
  logic                rst_b;
  fpfc_pkg::fpfc_cmp_t cmp_tb;
  fpfc_pkg::fpfc_cmp_t cmp;
  fpfc_pkg::fpfc_apb_t apb;
  logic [7:0]          fb_level;
  logic [31:0]         prdata;
  logic                pready;
  logic                pslverr;
  logic                gate_drive;
  logic [7:0]          cl_ref;
  logic                deep_green;
  logic                burst_off;
  logic                fet_lim;
  logic [15:0]         trip;
  logic [31:0]         rd;
  logic                err;
  int                  n;
  int                  errors;
  int                  compares;

  // Short counts keep the run brief
  fpfc_core #(.OPEN_CYC(200), .THERM_CYC(100), .HOP_CYC(2000), .SOFT_CYC(512),
              .LATCH_ALL(1'b0)) DUT (.clk(clk), .rst_b(rst_b), .cmp(cmp),
    .fb_level(fb_level), .apb(apb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .gate_drive(gate_drive), .cl_ref(cl_ref), .deep_green(deep_green), .burst_off(burst_off));
  fpfc_fet_model FET (.clk(clk), .gate_drive(gate_drive), .trip(trip), .cs_limit(fet_lim));

  always_comb
  begin
    cmp          = cmp_tb;
    cmp.cs_limit = fet_lim;
  end

  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic wrap_up;
    $display("Compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : wrap_up

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic cyc(input int k);
    repeat (k) @(posedge clk);
  endtask : cyc

  task automatic apb_xfer(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int w;
    w = 0;
    @(posedge clk);
    apb <= '{1'b1, 1'b0, wr, a, d};
    @(posedge clk);
    apb.penable <= 1'b1;
    do
    begin
      @(posedge clk);
      w++;
    end while (pready !== 1'b1 && w < 50);
    rd = prdata;
    err = pslverr;
    apb <= '0;
    if (pready !== 1'b1)
    begin
      errors++;
      wrap_up;
    end
  endtask : apb_xfer

  task automatic st(input logic [1:0] e);
    apb_xfer(1'b0, fpfc_pkg::A_STATUS, 32'h0);
    chk(32'(rd[3:2]), 32'(e));
  endtask : st

  // Sticky cause bits, then write-one-to-clear
  task automatic cause(input logic [5:0] e);
    apb_xfer(1'b0, fpfc_pkg::A_CAUSE, 32'h0);
    chk(rd, 32'(e));
    apb_xfer(1'b1, fpfc_pkg::A_CAUSE, 32'h3f);
    apb_xfer(1'b0, fpfc_pkg::A_CAUSE, 32'h0);
    chk(rd, 32'h0);
  endtask : cause

  // Waits for a gate rising edge, returns cycles waited
  task automatic rise(input int lim, output int k);
    logic prev;
    k = 0;
    do
    begin
      prev = gate_drive;
      @(posedge clk);
      k++;
    end while (!(gate_drive === 1'b1 && prev !== 1'b1) && k < lim);
    if (!(gate_drive === 1'b1 && prev !== 1'b1))
    begin
      errors++;
      wrap_up;
    end
  endtask : rise

  task automatic quiet(input int k, output int hi);
    hi = 0;
    repeat (k)
    begin
      @(posedge clk);
      if (gate_drive !== 1'b0)
        hi++;
    end
  endtask : quiet

  task automatic hold(input int b, input int k);
    cmp_tb[b] <= 1'b1;
    cyc(k);
    cmp_tb[b] <= 1'b0;
  endtask : hold

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_startup;
    quiet(300, n);
    chk(32'(n), 32'h0);
    apb_xfer(1'b0, fpfc_pkg::A_CTRL, 32'h0);
    chk(rd, 32'h3);
    apb_xfer(1'b0, 12'h010, 32'h0);
    chk(32'(err), 32'h1);
    st(2'h0);
    cmp_tb.vdd_on <= 1'b1;
    cyc(10);
    chk(32'(cl_ref < fpfc_pkg::SAW_VALLEY), 32'h1);
    rise(1000, n);
    st(2'h1);
  endtask : t_startup

  task automatic t_saw;
    logic [7:0] a;
    rise(1000, n);
    // Value launched at the wrap still shows the flat top
    cyc(1);
    a = cl_ref;
    cyc(100);
    chk(32'(cl_ref > a && a >= fpfc_pkg::SAW_VALLEY), 32'h1);
  endtask : t_saw

  task automatic t_hop;
    logic [31:0] lo;
    logic [31:0] hi;
    lo = '1;
    hi = '0;
    repeat (8)
    begin
      cyc(250);
      apb_xfer(1'b0, fpfc_pkg::A_PERIOD, 32'h0);
      if (rd < lo)
        lo = rd;
      if (rd > hi)
        hi = rd;
    end
    chk(32'(lo >= fpfc_pkg::P_HOPMIN && hi <= fpfc_pkg::P_HOPMAX && hi > lo), 32'h1);
  endtask : t_hop

  task automatic t_nominal;
    apb_xfer(1'b1, fpfc_pkg::A_CTRL, 32'h1);
    // A wrap on the write edge still takes a hop period
    rise(1000, n);
    rise(1000, n);
    rise(1000, n);
    chk(32'(n), 32'(fpfc_pkg::P_NOM));
    trip <= 16'h1;
    rise(1000, n);
    n = 0;
    while (gate_drive === 1'b1 && n < 500)
    begin
      @(posedge clk);
      n++;
    end
    // Sense flag is high long before blanking ends
    chk(32'(n >= fpfc_pkg::BLANK_CYC && n <= fpfc_pkg::BLANK_CYC + 5), 32'h1);
    trip <= 16'd200;
  endtask : t_nominal

  task automatic t_green;
    logic [31:0] prev;
    prev = 32'(fpfc_pkg::P_NOM);
    cmp_tb.fb_nred <= 1'b1;
    for (int i = 0; i < 3; i++)
    begin
      fb_level <= 8'(200 - 100 * i);
      cyc(4000);
      apb_xfer(1'b0, fpfc_pkg::A_PERIOD, 32'h0);
      chk(32'(rd > prev && rd <= fpfc_pkg::P_GREEN), 32'h1);
      prev = rd;
    end
    cmp_tb.fb_min <= 1'b1;
    cyc(4000);
    apb_xfer(1'b0, fpfc_pkg::A_PERIOD, 32'h0);
    chk(rd, 32'(fpfc_pkg::P_GREEN));
    chk(32'(deep_green), 32'h1);
    cmp_tb.fb_zero <= 1'b1;
    cyc(5);
    quiet(3000, n);
    chk(32'(n), 32'h0);
    chk(32'(burst_off), 32'h1);
    cmp_tb.fb_zero <= 1'b0;
    cmp_tb.fb_min <= 1'b0;
    cmp_tb.fb_nred <= 1'b0;
    rise(2000, n);
  endtask : t_green

  // Interrupted holds must not trip; a full hold must
  task automatic fault(input int b, input int lim, input logic [1:0] e);
    hold(b, lim - 20);
    cyc(3);
    hold(b, lim - 20);
    cyc(5);
    st(2'h1);
    hold(b, lim + 20);
    cyc(5);
    quiet(800, n);
    chk(32'(n), 32'h0);
    st(e);
  endtask : fault

  task automatic recover(input logic latched);
    cmp_tb.vdd_on <= 1'b0;
    cmp_tb.vdd_off <= 1'b1;
    cyc(5);
    if (latched)
    begin
      st(2'h3);
      cmp_tb.vdd_clear <= 1'b1;
      cyc(5);
    end
    st(2'h0);
    cmp_tb.vdd_clear <= 1'b0;
    cmp_tb.vdd_off <= 1'b0;
    cmp_tb.vdd_on <= 1'b1;
    rise(1000, n);
    st(2'h1);
  endtask : recover

  task automatic t_warn;
    cmp_tb.therm_warn <= 1'b1;
    cyc(130);
    quiet(200, n);
    chk(32'(n), 32'h0);
    st(2'h1);
    cmp_tb.therm_warn <= 1'b0;
    rise(1000, n);
  endtask : t_warn

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial
  begin
    errors = 0;
    compares = 0;
    rst_b = 1'b0;
    cmp_tb = '0;
    apb = '0;
    fb_level = 8'h00;
    trip = 16'd200;
    cyc(8);
    rst_b <= 1'b1;
    t_startup;
    t_saw;
    t_hop;
    t_nominal;
    t_green;
    fault(5, 200, 2'h2);
    cause(6'h01);
    recover(1'b0);
    fault(3, 200, 2'h2);
    cause(6'h02);
    recover(1'b0);
    fault(9, fpfc_pkg::VOVER_CYC, 2'h3);
    cause(6'h04);
    recover(1'b1);
    fault(0, fpfc_pkg::THERM2_CYC, 2'h3);
    cause(6'h10);
    recover(1'b1);
    hold(2, 5);
    cyc(5);
    st(2'h2);
    cause(6'h20);
    recover(1'b0);
    t_warn;
    wrap_up;
  end
endmodule : tb_flyback_pwm_fault_control
`default_nettype wire
